// >>> hdl/lamp_driver.sv
// core side of the serial status lamp driver with its apb registers
// Notes on behaviour
// - one lamp per port, dark whenever that port has no link
// - link without traffic shows the lamp steadily lit
// - occasional traffic keeps lamp lit with brief 1/16 s dark dips
// - heavy traffic flashes the lamp at 8 Hz
// - partitioned port repeats 0.5 s lit then 1.5 s dark
// - partition-only select shows only partition state, no link or activity
// - serial lamp data is active low, low means lit
// - shift sixteen bits, then one latch pulse, every 1/16 s
// - order: software lamps 1 to 4, flow lamp, ports 0 to 9
// - each software lamp slot mirrors its own control bit
// - flow lamp lit only while flow control is enabled and active
// - each port slot carries the pattern of its own port
// - last bit is the config fault lamp, lit on checksum failure
// - during reset data is driven low and clock and strobe run faster
`timescale 1ns/100ps
module lamp_driver
    import lamp_pkg::*;
#(
    parameter int unsigned update_cycles = UPDATE_CYCLES
)
(
    // core clock and reset
    input wire logic clk,
    input wire logic reset,
    // lamp link clock
    input wire logic link_clk,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // port state from the switch core
    input wire logic [9:0] port_link,
    input wire logic [9:0] port_frame,
    input wire logic [9:0] port_partitioned,
    // flow control and configuration state
    input wire logic flow_active,
    input wire logic cfg_crc_fail,
    // lamp chain pins
    output logic lamp_serial_out,
    output logic lamp_shift_clock,
    output logic lamp_latch_strobe
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam logic [23:0] TICK_LAST = 24'(update_cycles - 1);

    logic [5:0] ctrl_reg;
    logic [23:0] tick_cnt_reg;
    logic tick_reg;
    logic [4:0] phase_reg;
    logic [9:0] heavy_reg;
    logic [9:0] occas_reg;
    logic [9:0] port_lit;
    logic [15:0] word_next;
    logic [15:0] word_reg;
    logic req_reg;
    logic ack_meta_reg;
    logic ack_sync_reg;
    logic ack_toggle;
    logic pending;
    logic apb_setup;
    logic apb_access;
    logic [31:0] rdata_next;
    logic err_next;

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable && pready;
    assign pending = (req_reg != ack_sync_reg);

    // read mux and decode of unmapped offsets
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        err_next = 1'b0;
        if (paddr == LAMP_CTRL_OFS)
        begin
            rdata_next[5:0] = ctrl_reg;
        end
        else if (paddr == LAMP_STATUS_OFS)
        begin
            rdata_next[15:0] = word_reg;
            rdata_next[STAT_PEND_POS] = pending;
            err_next = pwrite;
        end
        else
        begin
            err_next = 1'b1;
        end
    end

    // one wait-free access cycle: pready rises in the cycle after setup
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (apb_setup)
        begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rdata_next;
            pslverr <= err_next;
        end
        else
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // control register, written only at the completing access edge
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_reg <= LAMP_CTRL_RESET;
        end
        else if (apb_access && pwrite && (paddr == LAMP_CTRL_OFS))
        begin
            ctrl_reg <= pwdata[5:0];
        end
    end

    // ------------------------------------------------------------------
    // update tick and blink phase
    // ------------------------------------------------------------------
    // one tick per 1/16 s; every blink pattern is a multiple of it
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tick_cnt_reg <= 24'h00_0000;
            tick_reg <= 1'b0;
        end
        else if (tick_cnt_reg == TICK_LAST)
        begin
            tick_cnt_reg <= 24'h00_0000;
            tick_reg <= 1'b1;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_reg + 24'h00_0001;
            tick_reg <= 1'b0;
        end
    end

    // 32 ticks make the 2 s partition cycle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            phase_reg <= 5'h00;
        end
        else if (tick_reg)
        begin
            phase_reg <= phase_reg + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // per port traffic class and lamp pattern
    // ------------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++)
        begin : g_port
            logic [3:0] frames_reg;

            // saturating count; a frame in the tick cycle starts the next count
            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    frames_reg <= 4'h0;
                    heavy_reg[p] <= 1'b0;
                    occas_reg[p] <= 1'b0;
                end
                else if (tick_reg)
                begin
                    frames_reg <= port_frame[p] ? 4'h1 : 4'h0;
                    heavy_reg[p] <= (frames_reg >= HEAVY_FRAMES);
                    occas_reg[p] <= (frames_reg != 4'h0) && (frames_reg < HEAVY_FRAMES);
                end
                else if (port_frame[p] && (frames_reg != 4'hF))
                begin
                    frames_reg <= frames_reg + 4'h1;
                end
            end

            // priority: no link, partition, partition-only select, then traffic class
            always_comb
            begin
                if (!port_link[p])
                begin
                    port_lit[p] = 1'b0;
                end
                else if (port_partitioned[p])
                begin
                    port_lit[p] = (phase_reg < PART_ON_TICKS);
                end
                else if (ctrl_reg[CTRL_PARTITION_ONLY_SEL_POS])
                begin
                    port_lit[p] = 1'b0;
                end
                else if (heavy_reg[p])
                begin
                    port_lit[p] = !phase_reg[0];
                end
                else if (occas_reg[p])
                begin
                    port_lit[p] = (phase_reg[2:0] != OCCAS_DIP_PHASE);
                end
                else
                begin
                    port_lit[p] = 1'b1;
                end
            end

            assign word_next[PORT0_POS - p] = port_lit[p];
        end
    endgenerate

    // ------------------------------------------------------------------
    // lamp word assembly, lit is one here and inverted on the pin
    // ------------------------------------------------------------------
    assign word_next[SW_LAMP1_POS] = ctrl_reg[CTRL_SW_POS];
    assign word_next[SW_LAMP1_POS - 1] = ctrl_reg[CTRL_SW_POS + 1];
    assign word_next[SW_LAMP1_POS - 2] = ctrl_reg[CTRL_SW_POS + 2];
    assign word_next[SW_LAMP1_POS - 3] = ctrl_reg[CTRL_SW_POS + 3];
    assign word_next[FLOW_POS] = ctrl_reg[CTRL_FLOW_EN_POS] && flow_active;
    assign word_next[FAULT_POS] = cfg_crc_fail;

    // ------------------------------------------------------------------
    // crossing to the link domain
    // ------------------------------------------------------------------
    // word stays frozen while a handover is open, so the far side can
    // sample it without its own synchroniser; a late link just skips ticks
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            word_reg <= 16'h0000;
            req_reg <= 1'b0;
        end
        else if (tick_reg && !pending)
        begin
            word_reg <= word_next;
            req_reg <= !req_reg;
        end
    end

    // acknowledge toggle back from the link domain
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ack_meta_reg <= 1'b0;
            ack_sync_reg <= 1'b0;
        end
        else
        begin
            ack_meta_reg <= ack_toggle;
            ack_sync_reg <= ack_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // link side shifter
    // ------------------------------------------------------------------
    lamp_shifter u_shifter
    (
        .link_clk(link_clk),
        .reset(reset),
        .req_toggle(req_reg),
        .lamp_word(word_reg),
        .ack_toggle(ack_toggle),
        .lamp_serial_out(lamp_serial_out),
        .lamp_shift_clock(lamp_shift_clock),
        .lamp_latch_strobe(lamp_latch_strobe)
    );

endmodule : lamp_driver

// >>> common/lamp_pkg.sv
// shared constants for the serial status lamp driver
package lamp_pkg;

    // ------------------------------------------------------------------
    // clocking and update timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned UPDATE_PERIOD_US = 62500;
    localparam int unsigned UPDATE_CYCLES = UPDATE_PERIOD_US * CLK_MHZ;
    localparam int unsigned TICK_CNT_W = 24;

    // ------------------------------------------------------------------
    // blink patterns, counted in update ticks of 1/16 s
    // ------------------------------------------------------------------
    localparam int unsigned PHASE_W = 5;
    localparam logic [4:0] PART_ON_TICKS = 5'h08;
    localparam logic [2:0] OCCAS_DIP_PHASE = 3'h0;

    // ------------------------------------------------------------------
    // traffic classification
    // ------------------------------------------------------------------
    localparam int unsigned NUM_PORTS = 10;
    localparam int unsigned FRAME_CNT_W = 4;
    localparam logic [3:0] HEAVY_FRAMES = 4'h8;

    // ------------------------------------------------------------------
    // lamp word layout, bit 15 is shifted first
    // ------------------------------------------------------------------
    localparam int unsigned LAMP_BITS = 16;
    localparam int unsigned SW_LAMP1_POS = 15;
    localparam int unsigned FLOW_POS = 11;
    localparam int unsigned PORT0_POS = 10;
    localparam int unsigned FAULT_POS = 0;
    localparam logic [15:0] LAMP_ALL_LIT = 16'hFFFF;
    localparam logic [3:0] LAST_BIT = 4'hF;

    // ------------------------------------------------------------------
    // link side half periods of the shift clock, in link cycles minus one
    // ------------------------------------------------------------------
    localparam logic [1:0] HALF_NORMAL = 2'h3;
    localparam logic [1:0] HALF_FAST = 2'h0;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] LAMP_CTRL_OFS = 12'h000;
    localparam logic [11:0] LAMP_STATUS_OFS = 12'h004;
    localparam logic [5:0] LAMP_CTRL_RESET = 6'h00;
    localparam int unsigned CTRL_SW_POS = 0;
    localparam int unsigned CTRL_PARTITION_ONLY_SEL_POS = 4;
    localparam int unsigned CTRL_FLOW_EN_POS = 5;
    localparam int unsigned STAT_PEND_POS = 16;

    // link side shifter states
    typedef enum logic [1:0]
    {
        LINK_IDLE = 2'b00,
        LINK_SHIFT = 2'b01,
        LINK_LATCH = 2'b10
    } link_state_type;

endpackage : lamp_pkg

// >>> hdl/lamp_shifter.sv
// link clock side serial shifter for the lamp chain
`timescale 1ns/100ps
module lamp_shifter
    import lamp_pkg::*;
(
    // link clock and raw reset level
    input wire logic link_clk,
    input wire logic reset,
    // handshake from the core domain
    input wire logic req_toggle,
    input wire logic [15:0] lamp_word,
    output logic ack_toggle,
    // lamp chain pins
    output logic lamp_serial_out,
    output logic lamp_shift_clock,
    output logic lamp_latch_strobe
);

    // ------------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------------
    logic test_meta_reg;
    logic test_sync_reg;
    logic req_meta_reg;
    logic req_sync_reg;
    logic req_seen_reg;
    link_state_type state_reg;
    logic [1:0] half_cnt_reg;
    logic [3:0] bit_idx_reg;
    logic [15:0] shift_reg;
    logic [1:0] half_limit;

    // reset is sampled as a level so the chain keeps running in lamp test
    always_ff @(posedge link_clk)
    begin
        test_meta_reg <= reset;
        test_sync_reg <= test_meta_reg;
        req_meta_reg <= req_toggle;
        req_sync_reg <= req_meta_reg;
    end

    assign half_limit = test_sync_reg ? HALF_FAST : HALF_NORMAL;

    // ------------------------------------------------------------------
    // shift engine
    // ------------------------------------------------------------------
    // data moves with the falling shift clock, so it is steady at each rise
    always_ff @(posedge link_clk)
    begin
        case (state_reg)
            LINK_IDLE:
            begin
                half_cnt_reg <= 2'h0;
                bit_idx_reg <= 4'h0;
                lamp_shift_clock <= 1'b0;
                lamp_latch_strobe <= 1'b0;
                if (test_sync_reg)
                begin
                    shift_reg <= LAMP_ALL_LIT;
                    lamp_serial_out <= 1'b0;
                    req_seen_reg <= req_sync_reg;
                    ack_toggle <= req_sync_reg;
                    state_reg <= LINK_SHIFT;
                end
                else if (req_sync_reg != req_seen_reg)
                begin
                    shift_reg <= lamp_word;
                    lamp_serial_out <= ~lamp_word[15];
                    req_seen_reg <= req_sync_reg;
                    state_reg <= LINK_SHIFT;
                end
            end
            LINK_SHIFT:
            begin
                if (half_cnt_reg != half_limit)
                begin
                    half_cnt_reg <= half_cnt_reg + 2'h1;
                end
                else
                begin
                    half_cnt_reg <= 2'h0;
                    if (!lamp_shift_clock)
                    begin
                        lamp_shift_clock <= 1'b1;
                    end
                    else
                    begin
                        lamp_shift_clock <= 1'b0;
                        if (bit_idx_reg == LAST_BIT)
                        begin
                            lamp_latch_strobe <= 1'b1;
                            state_reg <= LINK_LATCH;
                        end
                        else
                        begin
                            bit_idx_reg <= bit_idx_reg + 4'h1;
                            shift_reg <= {shift_reg[14:0], 1'b0};
                            lamp_serial_out <= ~shift_reg[14];
                        end
                    end
                end
            end
            LINK_LATCH:
            begin
                if (half_cnt_reg != half_limit)
                begin
                    half_cnt_reg <= half_cnt_reg + 2'h1;
                end
                else
                begin
                    lamp_latch_strobe <= 1'b0;
                    ack_toggle <= req_seen_reg;
                    state_reg <= LINK_IDLE;
                end
            end
            default:
            begin
                // unknown power-up state falls back to idle
                state_reg <= LINK_IDLE;
                half_cnt_reg <= 2'h0;
                bit_idx_reg <= 4'h0;
                shift_reg <= LAMP_ALL_LIT;
                lamp_serial_out <= 1'b0;
                lamp_shift_clock <= 1'b0;
                lamp_latch_strobe <= 1'b0;
                req_seen_reg <= req_sync_reg;
                ack_toggle <= req_sync_reg;
            end
        endcase
        // lamp test pulls the data low in every state, even mid frame,
        // so a reset that cuts a normal frame lights only its not yet shifted bits; the next frame lights all lamps
        if (test_sync_reg)
        begin
            lamp_serial_out <= 1'b0;
        end
    end

endmodule : lamp_shifter

// >>> bench/lamp_driver_checker.sv
// concurrent checks on the apb answer and the lamp chain pins
`timescale 1ns/100ps
module lamp_driver_checker
(
    // clocks and reset
    input wire logic clk,
    input wire logic link_clk,
    input wire logic reset,
    // apb handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // lamp chain pins
    input wire logic lamp_serial_out,
    input wire logic lamp_shift_clock,
    input wire logic lamp_latch_strobe
);
    logic [4:0] rise_cnt_reg;
    logic cnt_valid_reg;
    logic shift_prev_reg;

    // shift edges since the last strobe; the frame cut by reset is not trusted
    always_ff @(posedge link_clk or posedge reset)
    begin
        if (reset)
        begin
            rise_cnt_reg <= 5'h00;
            cnt_valid_reg <= 1'b0;
            shift_prev_reg <= 1'b0;
        end
        else
        begin
            shift_prev_reg <= lamp_shift_clock;
            if (lamp_latch_strobe)
            begin
                rise_cnt_reg <= 5'h00;
                cnt_valid_reg <= 1'b1;
            end
            else if (lamp_shift_clock && !shift_prev_reg)
            begin
                rise_cnt_reg <= rise_cnt_reg + 5'h01;
            end
        end
    end

    property p_strobe_after_sixteen;
        @(posedge link_clk) disable iff (reset)
        $rose(lamp_latch_strobe) && cnt_valid_reg |-> rise_cnt_reg == 5'h10;
    endproperty
    a_strobe_after_sixteen: assert property (p_strobe_after_sixteen)
        else $error("strobe not after sixteen shift edges");

    property p_data_steady_rise;
        @(posedge link_clk) disable iff (reset)
        $rose(lamp_shift_clock) |-> $stable(lamp_serial_out);
    endproperty
    a_data_steady_rise: assert property (p_data_steady_rise)
        else $error("data moved with shift clock rise");

    property p_data_steady_high;
        @(posedge link_clk) disable iff (reset)
        lamp_shift_clock && $past(lamp_shift_clock) |-> $stable(lamp_serial_out);
    endproperty
    a_data_steady_high: assert property (p_data_steady_high)
        else $error("data moved while shift clock high");

    property p_strobe_clock_low;
        @(posedge link_clk) disable iff (reset)
        lamp_latch_strobe |-> !lamp_shift_clock;
    endproperty
    a_strobe_clock_low: assert property (p_strobe_clock_low)
        else $error("strobe while shift clock high");

    // these two watch the reset phase itself, so reset cannot disable them
    property p_lamp_test_low;
        @(posedge link_clk) reset [*6] |-> !lamp_serial_out;
    endproperty
    a_lamp_test_low: assert property (p_lamp_test_low)
        else $error("lamp data not low in reset");

    property p_lamp_test_fast;
        @(posedge link_clk) reset [*8] |-> ##[1:40] lamp_latch_strobe;
    endproperty
    a_lamp_test_fast: assert property (p_lamp_test_fast)
        else $error("lamp test strobe too slow");

    property p_answer_next;
        @(posedge clk) disable iff (reset) psel && !penable |=> pready;
    endproperty
    a_answer_next: assert property (p_answer_next)
        else $error("no answer after setup");

    property p_ready_single;
        @(posedge clk) disable iff (reset) pready |=> !pready;
    endproperty
    a_ready_single: assert property (p_ready_single)
        else $error("ready held too long");

    property p_err_in_access;
        @(posedge clk) disable iff (reset) pslverr |-> pready && psel && penable;
    endproperty
    a_err_in_access: assert property (p_err_in_access)
        else $error("error outside access");
endmodule : lamp_driver_checker

bind lamp_driver lamp_driver_checker i_chk (.clk(clk), .link_clk(link_clk), .reset(reset),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .lamp_serial_out(lamp_serial_out), .lamp_shift_clock(lamp_shift_clock),
    .lamp_latch_strobe(lamp_latch_strobe));

// >>> bench/lamp_chain_model.sv
// external shift register and latch chain behind the lamp pins
`timescale 1ns/100ps
module lamp_chain_model
(
    // lamp chain pins
    input wire logic lamp_serial_out,
    input wire logic lamp_shift_clock,
    input wire logic lamp_latch_strobe,
    // latched pin levels and frame bookkeeping
    output logic [15:0] shown,
    output int frames,
    output int shifts_at_latch,
    output realtime latch_time
);
    logic [15:0] chain = 16'h0000;
    int shifts = 0;

    initial frames = 0;

    // chain shifts on the rising shift clock, first bit ends up on top
    always @(posedge lamp_shift_clock)
    begin
        chain = {chain[14:0], lamp_serial_out};
        shifts = shifts + 1;
    end

    // outputs follow the chain only at the strobe
    always @(posedge lamp_latch_strobe)
    begin
        shown = chain;
        shifts_at_latch = shifts;
        shifts = 0;
        latch_time = $realtime;
        frames = frames + 1;
    end
endmodule : lamp_chain_model

// >>> bench/lamp_driver_tb.sv
// self-checking bench for the serial status lamp driver
`timescale 1ns/100ps
module lamp_driver_tb;
    import lamp_pkg::*;
    localparam int unsigned TICKS = 2000;
    logic clk, link_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] port_link, port_frame, port_partitioned;
    logic flow_active, cfg_crc_fail, err, sdo, sck, stb;
    logic [15:0] shown, w, prev;
    int frames, shifts_at_latch, f_mark;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int fcnt = 0;
    int lit_cnt[10];
    int toggles;
    realtime latch_time, last_t;
    int exp_cnt[10] = '{0, 32, 28, 16, 8, 0, 0, 32, 0, 32};

    lamp_driver #(.update_cycles(TICKS)) i_dut (.clk(clk), .reset(reset), .link_clk(link_clk),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_link(port_link),
        .port_frame(port_frame), .port_partitioned(port_partitioned),
        .flow_active(flow_active), .cfg_crc_fail(cfg_crc_fail), .lamp_serial_out(sdo),
        .lamp_shift_clock(sck), .lamp_latch_strobe(stb));

    lamp_chain_model i_chain (.lamp_serial_out(sdo), .lamp_shift_clock(sck),
        .lamp_latch_strobe(stb), .shown(shown), .frames(frames),
        .shifts_at_latch(shifts_at_latch), .latch_time(latch_time));

    // ------------------------------------------------------------------
    // clocks, frame traffic and timeout
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // link clock with an unrelated phase
    initial
    begin
        link_clk = 1'b0;
        #17;
        forever #32 link_clk = ~link_clk;
    end

    // port 3 heavy (13 or 14 per tick), port 2 occasional (2 or 3 per tick)
    always @(posedge clk)
    begin
        fcnt <= fcnt + 1;
        port_frame <= {6'h00, fcnt % 150 == 0, fcnt % 700 == 0, 2'h0};
        cycles <= cycles + 1;
        if (cycles == 100000)
        begin
            $display("[FAIL] %0t timeout waiting for frames", $time);
            failures = failures + 1;
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares = compares + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // next latched frame, as lit bits
    task next_frame();
        int f0;
        f0 = frames;
        while (frames == f0) @(posedge clk);
        w = ~shown;
    endtask : next_frame

    task give_verdict();
        $display("errors %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        port_link = 10'h29E;
        port_partitioned = 10'h030;
        flow_active = 1'b1;
        cfg_crc_fail = 1'b1;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, LAMP_CTRL_OFS, 32'h0);
        check(rd, 32'h0, "ctrl reset value");
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h0, "unmapped read data");
        check({31'h0, err}, 32'h1, "unmapped read error");
        apb(1'b1, LAMP_STATUS_OFS, 32'hFFFF);
        check({31'h0, err}, 32'h1, "status write");
        apb(1'b1, LAMP_CTRL_OFS, 32'h25);
        apb(1'b0, LAMP_CTRL_OFS, 32'h0);
        check(rd, 32'h25, "ctrl readback");
        repeat (3) next_frame();
        last_t = latch_time;
        prev = w;
        toggles = 0;
        foreach (lit_cnt[p]) lit_cnt[p] = 0;
        // 32 frames cover every blink pattern whatever the phase
        repeat (32)
        begin
            next_frame();
            check({27'h0, w[15:11]}, 32'h15, "sw and flow slots");
            check({31'h0, w[FAULT_POS]}, 32'h1, "fault slot");
            check(shifts_at_latch, 16, "bits per frame");
            check(latch_time - last_t > TICKS * 5 - 200, 1, "frame spacing low");
            check(latch_time - last_t < TICKS * 5 + 200, 1, "frame spacing high");
            last_t = latch_time;
            toggles = toggles + int'(w[PORT0_POS - 3] != prev[PORT0_POS - 3]);
            prev = w;
            foreach (lit_cnt[p]) lit_cnt[p] = lit_cnt[p] + w[PORT0_POS - p];
        end
        foreach (lit_cnt[p]) check(lit_cnt[p], exp_cnt[p], "port lit frames");
        check(toggles, 32, "heavy flashing");
        // partition only: link and activity vanish, flow enabled but idle
        apb(1'b1, LAMP_CTRL_OFS, 32'h3A);
        flow_active <= 1'b0;
        cfg_crc_fail <= 1'b0;
        repeat (3) next_frame();
        repeat (6)
        begin
            next_frame();
            check({16'h0, w & 16'hFFBF}, 32'h5000, "partition only frame");
        end
        // read within the latch pulse: word of this frame, ack still open
        apb(1'b0, LAMP_STATUS_OFS, 32'h0);
        check(rd & 32'hFFFF_FFBF, 32'h0001_5000, "status word pending");
        // mid-run reset long enough for whole lamp test frames
        reset <= 1'b1;
        f_mark = frames;
        repeat (1500) @(posedge clk);
        check({16'h0000, shown}, 32'h0, "lamp test pins");
        check(frames - f_mark > 1, 1, "lamp test frames fast");
        give_verdict();
    end
endmodule : lamp_driver_tb
